/* File: vblm_pkg.sv */
// Shared constants and types for the video black level monitor.
// Assumes byte-wide subaddress register access from the host port.
package vblm_pkg;

    // =========================================================
    // Register subaddresses
    localparam logic [7:0] ADDR_BLUE_TRIM   = 8'h1e;
    localparam logic [7:0] ADDR_GREEN_TRIM  = 8'h1f;
    localparam logic [7:0] ADDR_RED_TRIM    = 8'h20;
    localparam logic [7:0] ADDR_BLUE_LOW    = 8'h23;
    localparam logic [7:0] ADDR_GREEN_LOW   = 8'h24;
    localparam logic [7:0] ADDR_RED_LOW     = 8'h25;
    localparam logic [7:0] ADDR_LOOP_SWITCH = 8'h26;
    localparam logic [7:0] ADDR_HIGH_BITS   = 8'h27;
    localparam logic [7:0] ADDR_FILTER_COEF = 8'h28;
    localparam logic [7:0] ADDR_FIXED_SLOT  = 8'h29;
    localparam logic [7:0] ADDR_WINDOW_POS  = 8'h31;

    // =========================================================
    // Reset values
    localparam logic [5:0] TRIM_RST        = 6'h10;
    localparam logic [7:0] LOOP_SWITCH_RST = 8'h80;
    localparam logic [6:0] FILTER_COEF_RST = 7'h53;
    localparam logic [7:0] FIXED_SLOT_RST  = 8'h08;
    localparam logic [7:0] WINDOW_POS_RST  = 8'h5a;

    // =========================================================
    // Field positions
    localparam int SWITCH_BIT     = 7;
    localparam int VERT_LSB       = 3;
    localparam int HORIZ_LSB      = 0;
    localparam int TRIM_SIGN_BIT  = 5;
    localparam int HIGH_BLUE_LSB  = 0;
    localparam int HIGH_GREEN_LSB = 2;
    localparam int HIGH_RED_LSB   = 4;

    // =========================================================
    // Arithmetic constants
    localparam logic [9:0] LEVEL_MIDSCALE = 10'h200;
    localparam logic [3:0] VERT_MAX_SHIFT = 4'ha;
    localparam int         FRAC_BITS      = 10;
    localparam int         TRIM_STEP_SHIFT = 2;

    typedef enum logic [2:0]
    {
        WIN_IDLE    = 3'b001,
        WIN_PLACE   = 3'b010,
        WIN_MEASURE = 3'b100
    } vblm_win_state_type;

endpackage

/* File: vblm_window_if.sv */
// Carries the measurement window timing to the per-channel averagers.
// Assumes one clock domain shared by all users.
`timescale 1ns/1ps
interface vblm_window_if;
    logic       sample_en;
    logic       line_done;
    logic       enable;
    logic [2:0] horiz_code;
    logic [7:0] position;

    modport timer (output sample_en, output line_done,
                   input enable, input horiz_code, input position);
    modport filt  (input sample_en, input line_done, input horiz_code);
endinterface

/* File: vblm_window_timer.sv */
// Places the level measurement window after the chosen sync edge.
// Assumes the sync pin is asynchronous to i_clk.
`timescale 1ns/1ps
module vblm_window_timer
    import vblm_pkg::*;
(
    input  wire logic   i_clk,            // Sample clock
    input  wire logic   i_sys_rst,        // Synchronous reset
    input  wire logic   i_hsync,          // Sync pin, active high
    input  wire logic   i_edge_trailing,  // 1 = falling edge reference
    vblm_window_if.timer win              // Window timing out
);
    logic [2:0]         sync_pipe;
    logic               sync_level;
    logic               sync_edge;
    logic [7:0]         place_cnt;
    logic [8:0]         tap_cnt;
    vblm_win_state_type state;
    wire  [8:0]         taps = 9'd2 << win.horiz_code;

    // Change counts only once stages two and three agree
    assign sync_edge = (sync_pipe[1] == sync_pipe[2])
                     && (sync_pipe[2] != sync_level)
                     && (sync_pipe[2] == ~i_edge_trailing);
    assign win.sample_en = (state == WIN_MEASURE);
    assign win.line_done = win.sample_en && (tap_cnt == 9'd1);

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sync_pipe  <= 3'h0;
            sync_level <= 1'b0;
        end
        else
        begin
            sync_pipe <= {sync_pipe[1:0], i_hsync};
            if (sync_pipe[1] == sync_pipe[2])
                sync_level <= sync_pipe[2];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || !win.enable)
        begin
            state     <= WIN_IDLE;
            place_cnt <= 8'h0;
            tap_cnt   <= 9'h0;
        end
        else
        begin
            case (state)
                WIN_IDLE:
                    if (sync_edge)
                    begin
                        place_cnt <= win.position;
                        tap_cnt   <= taps;
                        state <= (win.position == 8'h0) ? WIN_MEASURE
                                                        : WIN_PLACE;
                    end
                WIN_PLACE:
                begin
                    place_cnt <= place_cnt - 8'd1;
                    if (place_cnt == 8'd1)
                        state <= WIN_MEASURE;
                end
                WIN_MEASURE:
                begin
                    tap_cnt <= tap_cnt - 9'd1;
                    if (tap_cnt == 9'd1)
                        state <= WIN_IDLE;
                end
                default:
                    state <= WIN_IDLE;
            endcase
        end
    end
endmodule

/* File: vblm_horiz_average.sv */
// Running average of one channel over the measurement window.
// Assumes window strobes from vblm_window_timer on the same clock.
`timescale 1ns/1ps
module vblm_horiz_average
    import vblm_pkg::*;
#(
    parameter int DATA_W = 10,
    parameter int SUM_W  = 18
)
(
    input  wire logic              i_clk,         // Sample clock
    input  wire logic              i_sys_rst,     // Synchronous reset
    input  wire logic [DATA_W-1:0] i_sample,      // ADC code
    vblm_window_if.filt            win,           // Window timing in
    output logic      [DATA_W-1:0] o_meas,        // Line measurement
    output logic                   o_meas_valid   // One-cycle pulse
);
    logic [SUM_W-1:0] sum;
    wire  [SUM_W-1:0] next_sum = sum + SUM_W'(i_sample);
    wire  [3:0]       shift    = {1'b0, win.horiz_code} + 4'd1;
    wire  [SUM_W-1:0] avg      = next_sum >> shift;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sum          <= '0;
            o_meas       <= '0;
            o_meas_valid <= 1'b0;
        end
        else
        begin
            // A window cut short leaves no partial sum behind
            sum          <= (win.sample_en && !win.line_done) ? next_sum : '0;
            o_meas_valid <= win.line_done;
            if (win.line_done)
                o_meas <= avg[DATA_W-1:0];
        end
    end
endmodule

/* File: vblm_level_monitor.sv */
// Three-channel black level monitor with host register file.
// Assumes ADC samples arrive one per i_clk and the host register
// port is already in the i_clk domain.
//
// Overview of operation
// - Readback equals filtered ADC code minus 512, 10-bit two's complement.
// - Low eight readback bits of blue, green, red in three read-only slots.
// - Shared high register holds red 5:4, green 3:2, blue 1:0.
// - Enable register bit 7 turns measurement on; resets to 80h.
// - Filtered result updates exactly once per video line.
// - Vertical stage is recursive with coefficient 1/2^n; codes above nine use 1/1024.
// - Code zero makes the result equal the newest line measurement.
// - Horizontal stage averages 2^(n+1) samples, 2 up to 256.
// - Filter register holds vertical code 6:3, horizontal 2:0; resets 53h.
// - Trim is sign-magnitude, bit 5 negative, 4 counts per step.
// - Three trim registers in bits 5:0, each resetting to 10h.
// - Window starts a programmed number of clocks after the sync edge.
`timescale 1ns/1ps
module vblm_level_monitor
    import vblm_pkg::*;
#(
    parameter int DATA_W = 10,
    parameter int SUM_W  = 18
)
(
    input  wire logic              i_clk,             // 200 MHz clock
    input  wire logic              i_sys_rst,         // Sync reset, high
    input  wire logic [DATA_W-1:0] i_adc_blue,        // Blue ADC code
    input  wire logic [DATA_W-1:0] i_adc_green,       // Green ADC code
    input  wire logic [DATA_W-1:0] i_adc_red,         // Red ADC code
    input  wire logic              i_hsync,           // Sync pin
    input  wire logic              i_edge_trailing,   // Window reference
    input  wire logic              i_reg_wr,          // Write strobe
    input  wire logic              i_reg_rd,          // Read strobe
    input  wire logic [7:0]        i_reg_addr,        // Subaddress
    input  wire logic [7:0]        i_reg_wdata,       // Write data
    output logic      [7:0]        o_reg_rdata,       // Read data
    output logic                   o_reg_rvalid,      // Read data valid
    output logic      [5:0]        o_blue_trim,       // Blue analog trim
    output logic      [5:0]        o_green_trim,      // Green analog trim
    output logic      [5:0]        o_red_trim,        // Red analog trim
    output logic signed [7:0]      o_blue_trim_cnt,   // Blue trim counts
    output logic signed [7:0]      o_green_trim_cnt,  // Green trim counts
    output logic signed [7:0]      o_red_trim_cnt,    // Red trim counts
    output logic                   o_line_update      // Update pulse
);
    localparam int ACC_W = DATA_W + FRAC_BITS;

    // =========================================================
    // Decoding helpers

    // Codes past ten all saturate at the slowest coefficient
    function automatic logic [3:0] vert_shift(input logic [3:0] code);
        vert_shift = (code > VERT_MAX_SHIFT) ? VERT_MAX_SHIFT : code;
    endfunction

    // Sign-magnitude trim code to signed ADC counts
    function automatic logic signed [7:0] trim_counts(
        input logic [5:0] code);
        logic [7:0] mag;
        mag = {1'b0, code[TRIM_SIGN_BIT-1:0], 2'b00};
        trim_counts = code[TRIM_SIGN_BIT] ? -$signed(mag)
                                          : $signed(mag);
    endfunction

    // =========================================================
    // Register state
    logic [5:0]  trim [3];
    logic        loop_on;
    logic [6:0]  filter_coef;
    logic [7:0]  fixed_slot;
    logic [7:0]  window_pos;
    logic [9:0]  readback [3];

    wire  [3:0]  vert_code  = filter_coef[6:VERT_LSB];
    wire  [2:0]  horiz_code = filter_coef[2:HORIZ_LSB];
    wire  [3:0]  vshift     = vert_shift(vert_code);

    wire wr_blue_trim   = i_reg_wr && (i_reg_addr == ADDR_BLUE_TRIM);
    wire wr_green_trim  = i_reg_wr && (i_reg_addr == ADDR_GREEN_TRIM);
    wire wr_red_trim    = i_reg_wr && (i_reg_addr == ADDR_RED_TRIM);
    wire wr_loop_switch = i_reg_wr && (i_reg_addr == ADDR_LOOP_SWITCH);
    wire wr_filter_coef = i_reg_wr && (i_reg_addr == ADDR_FILTER_COEF);
    wire wr_fixed_slot  = i_reg_wr && (i_reg_addr == ADDR_FIXED_SLOT);
    wire wr_window_pos  = i_reg_wr && (i_reg_addr == ADDR_WINDOW_POS);

    // =========================================================
    // Writable registers
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            trim[0]     <= TRIM_RST;
            trim[1]     <= TRIM_RST;
            trim[2]     <= TRIM_RST;
            loop_on     <= LOOP_SWITCH_RST[SWITCH_BIT];
            filter_coef <= FILTER_COEF_RST;
            fixed_slot  <= FIXED_SLOT_RST;
            window_pos  <= WINDOW_POS_RST;
        end
        else
        begin
            if (wr_blue_trim)
                trim[0] <= i_reg_wdata[5:0];
            if (wr_green_trim)
                trim[1] <= i_reg_wdata[5:0];
            if (wr_red_trim)
                trim[2] <= i_reg_wdata[5:0];
            if (wr_loop_switch)
                loop_on <= i_reg_wdata[SWITCH_BIT];
            if (wr_filter_coef)
                filter_coef <= i_reg_wdata[6:0];
            // Stored as written; the value that works is up to software
            if (wr_fixed_slot)
                fixed_slot <= i_reg_wdata;
            if (wr_window_pos)
                window_pos <= i_reg_wdata;
        end
    end

    // =========================================================
    // Trim outputs
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_blue_trim_cnt  <= 8'sh0;
            o_green_trim_cnt <= 8'sh0;
            o_red_trim_cnt   <= 8'sh0;
        end
        else
        begin
            o_blue_trim_cnt  <= trim_counts(trim[0]);
            o_green_trim_cnt <= trim_counts(trim[1]);
            o_red_trim_cnt   <= trim_counts(trim[2]);
        end
    end

    assign o_blue_trim  = trim[0];
    assign o_green_trim = trim[1];
    assign o_red_trim   = trim[2];

    // =========================================================
    // Window timing
    vblm_window_if win_bus ();

    assign win_bus.enable     = loop_on;
    assign win_bus.horiz_code = horiz_code;
    assign win_bus.position   = window_pos;

    vblm_window_timer u_timer
    (
        .i_clk           (i_clk),
        .i_sys_rst       (i_sys_rst),
        .i_hsync         (i_hsync),
        .i_edge_trailing (i_edge_trailing),
        .win             (win_bus)
    );

    // =========================================================
    // Per-channel filtering
    wire  [DATA_W-1:0] adc [3];
    logic [DATA_W-1:0] meas [3];
    logic [2:0]        meas_valid;
    logic [ACC_W-1:0]  level_acc [3];
    logic [ACC_W-1:0]  next_acc [3];

    assign adc[0] = i_adc_blue;
    assign adc[1] = i_adc_green;
    assign adc[2] = i_adc_red;

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++)
        begin : g_chan
            wire [ACC_W-1:0]  target = {meas[ch], FRAC_BITS'(0)};
            wire signed [ACC_W:0] diff =
                $signed({1'b0, target}) - $signed({1'b0, level_acc[ch]});
            wire signed [ACC_W:0] step = diff >>> vshift;

            vblm_horiz_average #(
                .DATA_W (DATA_W),
                .SUM_W  (SUM_W)
            ) u_avg
            (
                .i_clk        (i_clk),
                .i_sys_rst    (i_sys_rst),
                .i_sample     (adc[ch]),
                .win          (win_bus),
                .o_meas       (meas[ch]),
                .o_meas_valid (meas_valid[ch])
            );

            // Shift of zero takes the whole difference in one line
            assign next_acc[ch] = level_acc[ch] + step[ACC_W-1:0];

            always_ff @(posedge i_clk)
            begin
                if (i_sys_rst)
                begin
                    level_acc[ch] <= {LEVEL_MIDSCALE, FRAC_BITS'(0)};
                    readback[ch]  <= 10'h0;
                end
                else if (meas_valid[ch])
                begin
                    level_acc[ch] <= next_acc[ch];
                    // Both halves come from one register, one update
                    readback[ch]  <= {~next_acc[ch][ACC_W-1],
                                      next_acc[ch][ACC_W-2:FRAC_BITS]};
                end
            end
        end
    endgenerate

    // Line update pulse; no pulse while disabled, so state holds
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_line_update <= 1'b0;
        else
            o_line_update <= meas_valid[0];
    end

    // =========================================================
    // Read decode
    logic [7:0] rd_mux;
    wire  [7:0] high_bits = {2'b00,
                             readback[2][9:8],
                             readback[1][9:8],
                             readback[0][9:8]};

    always_comb
    begin
        if (i_reg_addr == ADDR_BLUE_TRIM)
            rd_mux = {2'b00, trim[0]};
        else if (i_reg_addr == ADDR_GREEN_TRIM)
            rd_mux = {2'b00, trim[1]};
        else if (i_reg_addr == ADDR_RED_TRIM)
            rd_mux = {2'b00, trim[2]};
        else if (i_reg_addr == ADDR_BLUE_LOW)
            rd_mux = readback[0][7:0];
        else if (i_reg_addr == ADDR_GREEN_LOW)
            rd_mux = readback[1][7:0];
        else if (i_reg_addr == ADDR_RED_LOW)
            rd_mux = readback[2][7:0];
        else if (i_reg_addr == ADDR_LOOP_SWITCH)
            rd_mux = {loop_on, 7'h00};
        else if (i_reg_addr == ADDR_HIGH_BITS)
            rd_mux = high_bits;
        else if (i_reg_addr == ADDR_FILTER_COEF)
            rd_mux = {1'b0, filter_coef};
        else if (i_reg_addr == ADDR_FIXED_SLOT)
            rd_mux = fixed_slot;
        else if (i_reg_addr == ADDR_WINDOW_POS)
            rd_mux = window_pos;
        else
            rd_mux = 8'h00;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
                o_reg_rdata <= rd_mux;
        end
    end
endmodule

/* File: vblm_level_monitor_properties.sv */
// Port-level checks for the black level monitor.
// Assumes it is bound into vblm_level_monitor on one clock domain.
`timescale 1ns/1ps
module vblm_level_monitor_properties
    import vblm_pkg::*;
#(
    parameter int DATA_W = 10,
    parameter int SUM_W  = 18
)
(
    input wire logic              i_clk,            // Clock
    input wire logic              i_sys_rst,        // Reset
    input wire logic              i_reg_wr,         // Write strobe
    input wire logic              i_reg_rd,         // Read strobe
    input wire logic [7:0]        i_reg_addr,       // Subaddress
    input wire logic [7:0]        i_reg_wdata,      // Write data
    input wire logic [7:0]        o_reg_rdata,      // Read data
    input wire logic              o_reg_rvalid,     // Read valid
    input wire logic [5:0]        o_blue_trim,      // Blue trim
    input wire logic [5:0]        o_green_trim,     // Green trim
    input wire logic [5:0]        o_red_trim,       // Red trim
    input wire logic signed [7:0] o_blue_trim_cnt,  // Blue counts
    input wire logic signed [7:0] o_green_trim_cnt, // Green counts
    input wire logic signed [7:0] o_red_trim_cnt,   // Red counts
    input wire logic              o_line_update     // Update pulse
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // =========================================================
    // Helper logic
    logic loop_on;
    wire  switch_wr = i_reg_wr && (i_reg_addr == ADDR_LOOP_SWITCH);
    wire  mapped    = i_reg_addr inside {ADDR_BLUE_TRIM, ADDR_GREEN_TRIM,
                      ADDR_RED_TRIM, [ADDR_BLUE_LOW:ADDR_FIXED_SLOT],
                      ADDR_WINDOW_POS};

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            loop_on <= 1'b1;
        else if (switch_wr)
            loop_on <= i_reg_wdata[SWITCH_BIT];
    end

    function automatic logic signed [7:0] cnt_of(input logic [5:0] c);
        logic signed [7:0] mag;
        mag = $signed({1'b0, c[4:0], 2'b00});
        return c[TRIM_SIGN_BIT] ? -mag : mag;
    endfunction

    sequence rd_req(a);
        i_reg_rd && (i_reg_addr == a);
    endsequence

    sequence line_gap;
        (!o_line_update) [*3];
    endsequence

    // =========================================================
    // Assertions
    rvalid_follows_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe not answered");
    rvalid_only_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("read valid without a read");
    rdata_holds_a: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
        else $error("read data moved between reads");
    unmapped_zero_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    trim_readback_a: assert property (rd_req(ADDR_BLUE_TRIM) |=>
        o_reg_rdata == {2'b00, $past(o_blue_trim)})
        else $error("trim read data wrong");
    high_reserved_a: assert property (rd_req(ADDR_HIGH_BITS) |=>
        o_reg_rdata[7:6] == 2'b00)
        else $error("high bits reserved field set");
    trim_reset_a: assert property ($fell(i_sys_rst) |-> o_blue_trim == TRIM_RST
        && o_green_trim == TRIM_RST && o_red_trim == TRIM_RST)
        else $error("trim reset value wrong");
    trim_count_a: assert property (1'b1 |=>
        o_blue_trim_cnt == cnt_of($past(o_blue_trim))
        && o_green_trim_cnt == cnt_of($past(o_green_trim))
        && o_red_trim_cnt == cnt_of($past(o_red_trim)))
        else $error("trim count mapping wrong");
    line_single_a: assert property (o_line_update |=> line_gap)
        else $error("line update not a lone pulse");
    frozen_off_a: assert property ((!loop_on) [*4] |-> !o_line_update)
        else $error("update while loop disabled");
endmodule

bind vblm_level_monitor vblm_level_monitor_properties
    #(.DATA_W(DATA_W), .SUM_W(SUM_W)) u_props
(
    .i_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .o_blue_trim, .o_green_trim, .o_red_trim,
    .o_blue_trim_cnt, .o_green_trim_cnt, .o_red_trim_cnt, .o_line_update
);

/* File: vblm_video_source.sv */
// Far side model: three ADC channels behind the analog trim, and sync.
// Assumes the bench sets blank levels and requests one line at a time.
`timescale 1ns/1ps
module vblm_video_source
(
    input  wire logic            i_clk,          // Sample clock
    input  wire logic            i_line_req,     // Start one line
    input  wire logic [2:0][9:0] i_level,        // Blank level b,g,r
    input  wire logic [2:0][7:0] i_trim_cnt,     // Analog trim counts
    output logic      [2:0][9:0] o_adc = '0,     // ADC codes
    output logic                 o_hsync = 1'b0  // Sync pin
);
    int hs_left = 0;

    // The converter clips, so a large negative trim saturates at zero
    function automatic logic [9:0] clip(input int v);
        return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3ff : 10'(v);
    endfunction

    always @(posedge i_clk)
        if (i_line_req)
            hs_left <= 16;
        else if (hs_left > 0)
            hs_left <= hs_left - 1;

    always @(negedge i_clk)
    begin
        o_hsync <= (hs_left > 0);
        for (int k = 0; k < 3; k++)
            o_adc[k] <= clip(int'(i_level[k]) + int'($signed(i_trim_cnt[k])));
    end
endmodule

/* File: vblm_level_monitor_tb.sv */
// Self-checking bench for the black level monitor.
// Assumes the video source model and the bound port checker.
`timescale 1ns/1ps
module vblm_level_monitor_tb
    import vblm_pkg::*;
;
    logic            clk, rst, wr, rd, edge_tr, line_req, rvalid, upd, hsync;
    logic [7:0]      addr, wdata, rdata;
    logic [2:0][5:0] trim;
    logic [2:0][7:0] cnt;
    logic [2:0][9:0] level, adc;
    int              err_total = 0;
    int              total_checks = 0;
    int              n_upd = 0;
    int              acc [3];
    logic [7:0] ra [12] = '{ADDR_BLUE_TRIM, ADDR_GREEN_TRIM, ADDR_RED_TRIM,
        ADDR_BLUE_LOW, ADDR_GREEN_LOW, ADDR_RED_LOW, ADDR_LOOP_SWITCH,
        ADDR_HIGH_BITS, ADDR_FILTER_COEF, ADDR_FIXED_SLOT, ADDR_WINDOW_POS,
        8'h40};
    logic [7:0] rv [12] = '{8'h10, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00,
        8'h80, 8'h00, 8'h53, 8'h08, 8'h5a, 8'h00};
    logic [7:0] tc [5] = '{8'h1f, 8'h3f, 8'h21, 8'hff, 8'h20};
    logic [7:0] tn [5] = '{8'h7c, 8'h84, 8'hfc, 8'h84, 8'h00};

    vblm_level_monitor u_dut
    (
        .i_clk(clk), .i_sys_rst(rst), .i_adc_blue(adc[0]),
        .i_adc_green(adc[1]), .i_adc_red(adc[2]), .i_hsync(hsync),
        .i_edge_trailing(edge_tr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_blue_trim(trim[0]),
        .o_green_trim(trim[1]), .o_red_trim(trim[2]),
        .o_blue_trim_cnt(cnt[0]), .o_green_trim_cnt(cnt[1]),
        .o_red_trim_cnt(cnt[2]), .o_line_update(upd)
    );

    vblm_video_source u_src
    (
        .i_clk(clk), .i_line_req(line_req), .i_level(level),
        .i_trim_cnt(cnt), .o_adc(adc), .o_hsync(hsync)
    );

    // =========================================================
    // Shared tasks
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr    = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        rd   = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk({9'h000, rvalid}, 10'h001);
        chk({2'b00, rdata}, {2'b00, e});
    endtask

    // One sync pulse; the span covers the longest placement and window
    task automatic run_line(input bit on, input int vert_recursive_coef);
        int         n0;
        logic [9:0] e;
        logic [7:0] hi;
        n0 = n_upd;
        hi = 8'h00;
        @(negedge clk);
        line_req = 1'b1;
        @(negedge clk);
        line_req = 1'b0;
        repeat (700) @(negedge clk);
        chk(10'(n_upd - n0), {9'h000, on});
        for (int k = 0; k < 3; k++)
        begin
            if (on)
                acc[k] += (int'(level[k]) * 1024 - acc[k]) >>> (vert_recursive_coef > 10 ? 10 : vert_recursive_coef);
            e = 10'((acc[k] >>> 10) - 512);
            reg_rd(ADDR_BLUE_LOW + 8'(k), e[7:0]);
            hi[2*k +: 2] = e[9:8];
        end
        reg_rd(ADDR_HIGH_BITS, hi);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =========================================================
    // Clock, counters and watchdog
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
        if (upd === 1'b1)
            n_upd++;

    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        $display("wrong value at %0t: run did not complete", $time);
        tally_and_finish();
    end

    // =========================================================
    // Test sequence
    initial
    begin
        {rst, wr, rd, line_req, edge_tr} = 5'b10001;
        {addr, wdata} = 16'h0000;
        level = '0;
        for (int k = 0; k < 3; k++)
            acc[k] = 512 * 1024;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 12; i++)
            reg_rd(ra[i], rv[i]);
        chk({2'b00, cnt[0]}, 10'h040);
        for (int i = 0; i < 5; i++)
            for (int k = 0; k < 3; k++)
            begin
                reg_wr(ADDR_BLUE_TRIM + 8'(k), tc[i]);
                reg_rd(ADDR_BLUE_TRIM + 8'(k), tc[i] & 8'h3f);
                chk({2'b00, cnt[k]}, {2'b00, tn[i]});
            end
        // Every vertical and horizontal code, each with its own levels
        for (int n = 0; n < 16; n++)
        begin
            for (int k = 0; k < 3; k++)
                level[k] = 10'((n * 157 + k * 341) % 1024);
            if (n == 0)
                level = {10'h2bc, 10'h200, 10'h020};
            edge_tr = n[0];
            reg_wr(ADDR_FILTER_COEF, {1'b1, n[3:0], n[2:0]});
            reg_rd(ADDR_FILTER_COEF, {1'b0, n[3:0], n[2:0]});
            run_line(1'b1, n);
        end
        reg_wr(ADDR_LOOP_SWITCH, 8'h00);
        reg_rd(ADDR_LOOP_SWITCH, 8'h00);
        level = {10'h3ff, 10'h000, 10'h155};
        run_line(1'b0, 0);
        reg_wr(ADDR_LOOP_SWITCH, 8'h80);
        run_line(1'b1, 15);
        tally_and_finish();
    end
endmodule
